// *** src/eer_top.v ***
// Error reporting top: serial command slave, status, trap and counter.
`default_nettype none
`include "eer_defines.vh"

module eer_top (
  // Clock and reset
  input wire mclk,
  input wire rstn,
  // Other reset events and power state
  input wire reset_event,
  input wire deep_power_down,
  // Serial memory bus pins
  input wire sck,
  input wire cs_n,
  input wire si,
  output reg so,
  output reg so_oe,
  // Array read results
  input wire rd_valid,
  input wire [23:0] rd_addr,
  input wire rd_special,
  input wire [63:0] rd_data,
  input wire [63:0] rd_err_mask,
  // Unit probe request to the array
  output reg probe_req,
  output reg [23:0] probe_addr,
  // Corrected unit write-back
  output reg wb_valid,
  output reg [23:0] wb_addr,
  output reg [63:0] wb_data
);

  localparam ST_OPC = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_OUT = 4'h4;
  localparam ST_DONE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////

  reg [1:0] rst_sync_reg;
  wire rst_n;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////////

  // Pin order in the vectors is si, cs_n, sck.
  reg [2:0] pin_s1_reg;
  reg [2:0] pin_s2_reg;
  reg [2:0] pin_s3_reg;
  reg [2:0] pin_lvl_reg;
  wire [2:0] pin_agree;
  wire [2:0] pin_lvl_next;
  wire sck_rise;
  wire sck_fall;
  wire sel_n;
  wire si_lvl;

  assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
  assign pin_lvl_next = (pin_agree & pin_s3_reg) | (~pin_agree & pin_lvl_reg);
  assign sck_rise = pin_lvl_next[0] & ~pin_lvl_reg[0];
  assign sck_fall = ~pin_lvl_next[0] & pin_lvl_reg[0];
  assign sel_n = pin_lvl_next[1];
  assign si_lvl = pin_lvl_next[2];

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 3'h2;
      pin_s2_reg <= 3'h2;
      pin_s3_reg <= 3'h2;
      pin_lvl_reg <= 3'h2;
    end else begin
      pin_s1_reg <= {si, cs_n, sck};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_lvl_reg <= pin_lvl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  wire chk_valid;
  wire [20:0] chk_unit;
  wire chk_uncorr;
  wire chk_fix;
  wire [63:0] chk_data;

  eer_unit_check u_check (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(rd_valid),
    .in_addr(rd_addr),
    .in_special(rd_special),
    .in_data(rd_data),
    .in_err_mask(rd_err_mask),
    .out_valid(chk_valid),
    .out_unit(chk_unit),
    .out_uncorr(chk_uncorr),
    .out_fix(chk_fix),
    .out_data(chk_data)
  );

  ////////////////////////////////////////////////////////////////////////////////

  reg flag_reg;
  reg flag_next;
  reg trap_held_reg;
  reg trap_held_next;
  reg [31:0] trap_reg;
  reg [31:0] trap_next;
  reg [15:0] count_reg;
  reg [15:0] count_next;
  reg clear_reg;
  wire detect;
  wire wipe;
  wire [7:0] status_value;

  assign detect = chk_valid & chk_uncorr;
  // Resets and power-down win over a same-cycle detection, the clear command does not.
  assign wipe = reset_event | deep_power_down;
  assign status_value = {3'h0, flag_reg, 4'h0};

  always @* begin
    flag_next = flag_reg;
    trap_next = trap_reg;
    trap_held_next = trap_held_reg;
    count_next = count_reg;
    if (wipe) begin
      flag_next = 1'b0;
      trap_next = `EER_TRAP_RST;
      trap_held_next = 1'b0;
      count_next = `EER_COUNT_RST;
    end else begin
      if (clear_reg) begin
        flag_next = 1'b0;
        trap_next = `EER_TRAP_RST;
        trap_held_next = 1'b0;
        count_next = `EER_COUNT_RST;
      end
      if (detect) begin
        flag_next = 1'b1;
        if (!trap_held_reg || clear_reg) begin
          trap_next = {11'h000, chk_unit};
          trap_held_next = 1'b1;
        end
        if (clear_reg) begin
          count_next = 16'h0001;
        end else if (count_reg != `EER_COUNT_MAX) begin
          count_next = count_reg + 16'h0001;
        end
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
      trap_reg <= `EER_TRAP_RST;
      trap_held_reg <= 1'b0;
      count_reg <= `EER_COUNT_RST;
    end else begin
      flag_reg <= flag_next;
      trap_reg <= trap_next;
      trap_held_reg <= trap_held_next;
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_valid <= 1'b0;
      wb_addr <= 24'h000000;
      wb_data <= 64'h0000000000000000;
    end else begin
      wb_valid <= chk_valid & chk_fix;
      if (chk_valid && chk_fix) begin
        wb_addr <= {chk_unit, 3'h0};
        wb_data <= chk_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  reg [3:0] state_reg;
  reg [4:0] bit_cnt_reg;
  reg [7:0] opcode_reg;
  reg [23:0] addr_reg;
  reg [31:0] out_shift_reg;
  reg probe_pend_reg;
  wire [7:0] opc_in;
  wire [23:0] addr_in;

  assign opc_in = {opcode_reg[6:0], si_lvl};
  assign addr_in = {addr_reg[22:0], si_lvl};

  // Only whole registers are returned; byte addresses inside one are not decoded.
  function [31:0] eer_reg_value;
    input [23:0] ra;
    input [7:0] st;
    input [15:0] cnt;
    input [31:0] trp;
    begin
      case (ra)
        `EER_RA_STATUS: eer_reg_value = {st, 24'h000000};
        `EER_RA_COUNT: eer_reg_value = {cnt, 16'h0000};
        `EER_RA_TRAP: eer_reg_value = trp;
        default: eer_reg_value = 32'h00000000;
      endcase
    end
  endfunction

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_OPC;
      bit_cnt_reg <= 5'h00;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      out_shift_reg <= 32'h00000000;
      probe_pend_reg <= 1'b0;
      probe_req <= 1'b0;
      probe_addr <= 24'h000000;
      clear_reg <= 1'b0;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      probe_req <= 1'b0;
      clear_reg <= 1'b0;
      if (sel_n) begin
        state_reg <= ST_OPC;
        bit_cnt_reg <= 5'h00;
        probe_pend_reg <= 1'b0;
        so <= 1'b0;
        so_oe <= 1'b0;
      end else begin
        so_oe <= (state_reg == ST_OUT);
        if (probe_pend_reg && detect_or_clean(chk_valid, chk_unit, probe_addr)) begin
          probe_pend_reg <= 1'b0;
          out_shift_reg <= {3'h0, chk_uncorr, 28'h0000000};
        end
        case (state_reg)
          ST_OPC: begin
            if (sck_rise) begin
              opcode_reg <= opc_in;
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == `EER_BIT_OPC_LAST) begin
                bit_cnt_reg <= 5'h00;
                if (opc_in == `EER_OP_CLEAR) begin
                  clear_reg <= 1'b1;
                  state_reg <= ST_DONE;
                end else if (opc_in == `EER_OP_UNIT_STATUS || opc_in == `EER_OP_REG_READ) begin
                  state_reg <= ST_ADDR;
                end else begin
                  state_reg <= ST_DONE;
                end
              end
            end
          end
          ST_ADDR: begin
            if (sck_rise) begin
              addr_reg <= addr_in;
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == `EER_BIT_ADDR_LAST) begin
                bit_cnt_reg <= 5'h00;
                state_reg <= ST_OUT;
                out_shift_reg <= 32'h00000000;
                if (opcode_reg == `EER_OP_UNIT_STATUS) begin
                  probe_req <= 1'b1;
                  probe_addr <= {addr_in[23:3], 3'h0};
                  probe_pend_reg <= 1'b1;
                end else begin
                  out_shift_reg <= eer_reg_value(addr_in, status_value, count_reg, trap_reg);
                end
              end
            end
          end
          ST_OUT: begin
            if (sck_fall) begin
              so <= out_shift_reg[31];
              out_shift_reg <= {out_shift_reg[30:0], 1'b0};
            end
          end
          ST_DONE: begin
            so <= 1'b0;
          end
          default: begin
            state_reg <= ST_OPC;
          end
        endcase
      end
    end
  end

  function detect_or_clean;
    input v;
    input [20:0] unit;
    input [23:0] pa;
    begin
      detect_or_clean = v & (unit == pa[23:3]);
    end
  endfunction

endmodule // eer_top

`default_nettype wire

// *** pkg/eer_defines.vh ***
// Constants for the array error detection and reporting block.
`ifndef EER_DEFINES_VH
`define EER_DEFINES_VH

`define EER_OP_UNIT_STATUS 8'h19
`define EER_OP_CLEAR 8'h1B
`define EER_OP_REG_READ 8'h65

`define EER_RA_STATUS 24'h000010
`define EER_RA_COUNT 24'h000011
`define EER_RA_TRAP 24'h000012

`define EER_FLAG_BIT 4
`define EER_UNIT_LSB 3
`define EER_STATUS_RST 8'h00
`define EER_COUNT_RST 16'h0000
`define EER_COUNT_MAX 16'hFFFF
`define EER_TRAP_RST 32'h00000000
`define EER_FIX_MAX 7'h02

`define EER_BIT_OPC_LAST 5'h07
`define EER_BIT_ADDR_LAST 5'h17
`define EER_BIT_STATUS_LAST 5'h07
`define EER_BIT_REG_LAST 5'h1F

`endif

// *** src/eer_unit_check.v ***
// Per-unit error classification and correction stage.
`default_nettype none
`include "eer_defines.vh"

module eer_unit_check (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Raw unit from the array sense path
  input wire in_valid,
  input wire [23:0] in_addr,
  input wire in_special,
  input wire [63:0] in_data,
  input wire [63:0] in_err_mask,
  // Classified unit
  output reg out_valid,
  output reg [20:0] out_unit,
  output reg out_uncorr,
  output reg out_fix,
  output reg [63:0] out_data
);

  function [6:0] eer_popcount;
    input [63:0] v;
    integer i;
    begin
      eer_popcount = 7'h00;
      for (i = 0; i < 64; i = i + 1) begin
        eer_popcount = eer_popcount + {6'h00, v[i]};
      end
    end
  endfunction

  wire [6:0] flips;
  wire checked;

  assign flips = eer_popcount(in_err_mask);
  assign checked = in_valid & ~in_special;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_unit <= 21'h00000;
      out_uncorr <= 1'b0;
      out_fix <= 1'b0;
      out_data <= 64'h0000000000000000;
    end else begin
      out_valid <= checked;
      out_unit <= in_addr[23:`EER_UNIT_LSB];
      out_uncorr <= checked & (flips > `EER_FIX_MAX);
      out_fix <= checked & (flips != 7'h00) & (flips <= `EER_FIX_MAX);
      if (flips <= `EER_FIX_MAX) begin
        out_data <= in_data ^ in_err_mask;
      end else begin
        out_data <= in_data;
      end
    end
  end

endmodule // eer_unit_check

`default_nettype wire

// *** dv/eer_host_model.sv ***
// Host serial bus controller model.
`default_nettype none
`include "eer_defines.vh"
module eer_host_model (
  // Serial bus pins
  output var logic sck,
  output var logic cs_n,
  output var logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Clock stands low between frames; odd start keeps edges off mclk.
  task automatic xfer(input logic [7:0] op, input logic [23:0] ad, input int na,
    input int nr, output logic [31:0] dout);
    logic [31:0] sh;
    sh = {op, ad};
    dout = 32'h0;
    #7 cs_n = 1'b0;
    for (int i = 0; i < 8 + na + nr; i++) begin
      si = (i < 8 + na) ? sh[31 - i] : ~si;
      #24 sck = 1'b1;
      if (i >= 8 + na)
        dout = {dout[30:0], so};
      #24 sck = 1'b0;
    end
    #24 cs_n = 1'b1;
    si = ~si;
    #95;
  endtask
  task automatic err_seen(output logic seen);
    logic [31:0] st;
    logic [31:0] ct;
    xfer(`EER_OP_REG_READ, `EER_RA_STATUS, 24, 8, st);
    xfer(`EER_OP_REG_READ, `EER_RA_COUNT, 24, 16, ct);
    seen = st[4] | (ct[15:0] != 16'h0);
  endtask
endmodule // eer_host_model
`default_nettype wire

// *** dv/eer_top_monitor.sv ***
// Port checker for the error reporting top.
`default_nettype none
module eer_top_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Watched ports
  input wire logic cs_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic rd_valid,
  input wire logic [23:0] rd_addr,
  input wire logic rd_special,
  input wire logic [63:0] rd_data,
  input wire logic [63:0] rd_err_mask,
  input wire logic probe_req,
  input wire logic [23:0] probe_addr,
  input wire logic wb_valid,
  input wire logic [23:0] wb_addr,
  input wire logic [63:0] wb_data
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_fix;
    rd_valid && !rd_special && $countones(rd_err_mask) inside {[1:2]};
  endsequence
  sequence s_fixed_out;
    wb_valid && wb_data == ($past(rd_data, 2) ^ $past(rd_err_mask, 2))
      && wb_addr == ($past(rd_addr, 2) & 24'hFFFFF8);
  endsequence
  sequence s_probe;
    probe_addr[2:0] == 3'h0 ##1 !probe_req;
  endsequence
  a_fix_write_back: assert property (s_fix |-> ##2 s_fixed_out)
    else $error("corrected unit not written back");
  a_uncorr_no_wb: assert property (
    rd_valid && $countones(rd_err_mask) > 2 |-> ##2 !wb_valid)
    else $error("uncorrectable unit written back");
  a_special_no_wb: assert property (rd_valid && rd_special |-> ##2 !wb_valid)
    else $error("special sector unit written back");
  a_clean_no_wb: assert property (rd_valid && rd_err_mask == 64'h0 |-> ##2 !wb_valid)
    else $error("clean unit written back");
  a_wb_has_cause: assert property (wb_valid |-> $past(rd_valid, 2))
    else $error("write-back without a read");
  a_probe_unit: assert property (probe_req |-> s_probe)
    else $error("probe not aligned or not a pulse");
  a_idle_quiet: assert property (cs_n [*6] |-> !so_oe)
    else $error("output driven while deselected");
  a_so_gated: assert property (!so_oe |-> !so)
    else $error("data out while not driving");
endmodule // eer_top_monitor
bind eer_top eer_top_monitor u_mon (.mclk, .rstn, .cs_n, .so, .so_oe, .rd_valid, .rd_addr,
  .rd_special, .rd_data, .rd_err_mask, .probe_req, .probe_addr, .wb_valid, .wb_addr, .wb_data);
`default_nettype wire

// *** dv/eer_top_tb.sv ***
// Self-checking bench for the error reporting top.
`default_nettype none
`include "eer_defines.vh"
module eer_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, sck, cs_n, si, so, so_oe, probe_req, wb_valid, seen;
  logic rstn = 1'b0, reset_event = 1'b0, deep_power_down = 1'b0, pr_d = 1'b0;
  logic rd_valid = 1'b0, rd_special = 1'b0;
  logic [23:0] rd_addr = 24'h0, probe_addr, wb_addr;
  logic [63:0] rd_data = 64'h0, rd_err_mask = 64'h0, pmask = 64'h0, wb_data;
  logic [31:0] seed = 32'h1AA4, d;
  logic [20:0] ex_trap = 21'h0;
  logic [15:0] ex_cnt = 16'h0;
  logic ex_flag = 1'b0;
  int num_errors = 0, num_checks = 0, cyc = 0, k;
  // Probe answers are merged at the pins so each array input keeps a single driver.
  eer_top DUT (.mclk, .rstn, .reset_event, .deep_power_down, .sck, .cs_n, .si, .so, .so_oe,
    .rd_valid(rd_valid | pr_d), .rd_addr(pr_d ? probe_addr : rd_addr),
    .rd_special(rd_special & ~pr_d), .rd_data, .rd_err_mask(pr_d ? pmask : rd_err_mask),
    .probe_req, .probe_addr, .wb_valid, .wb_addr, .wb_data);
  eer_host_model host (.sck, .cs_n, .si, .so);
  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [63:0] mk(input int n);
    logic [63:0] m;
    m = 64'h0;
    while ($countones(m) < n)
      m[xs() % 64] = 1'b1;
    return m;
  endfunction
  function automatic void upd(input logic [23:0] a, input logic [63:0] m, input logic s);
    if (!s && $countones(m) > 2) begin
      if (!ex_flag)
        ex_trap = a[23:3];
      ex_flag = 1'b1;
      if (ex_cnt != 16'hFFFF)
        ex_cnt++;
    end
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic arr(input logic [23:0] a, input logic [63:0] m, input logic s);
    rd_valid <= 1'b1;
    rd_addr <= a;
    rd_data <= {xs(), xs()};
    rd_err_mask <= m;
    rd_special <= s;
    upd(a, m, s);
    @(posedge mclk);
  endtask
  task automatic regs(input string nm);
    host.xfer(`EER_OP_REG_READ, `EER_RA_STATUS, 24, 8, d);
    chk(d, {27'h0, ex_flag, 4'h0});
    host.xfer(`EER_OP_REG_READ, `EER_RA_COUNT, 24, 16, d);
    chk(d, {16'h0, ex_cnt});
    host.xfer(`EER_OP_REG_READ, `EER_RA_TRAP, 24, 32, d);
    chk(d, {11'h0, ex_trap});
    host.xfer(`EER_OP_REG_READ, 24'h000013, 24, 8, d);
    chk(d, 32'h0);
    $display("test %s done", nm);
    @(posedge mclk);
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // The array answers a probe on the next cycle, well before the status is shifted.
  always @(posedge mclk) begin
    pr_d <= probe_req;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (8) @(posedge mclk);
    regs("reset");
    arr(24'h000005, mk(3), 1'b0);
    for (int i = 0; i < 60; i++) begin
      k = xs() % 5;
      arr(24'(xs()), mk(k == 4 ? 3 : k), k == 4);
    end
    rd_valid <= 1'b0;
    @(posedge mclk);
    regs("random");
    host.xfer(`EER_OP_CLEAR, 24'h0, 0, 0, d);
    {ex_flag, ex_cnt, ex_trap} = '0;
    regs("clear");
    host.xfer(8'h05, 24'h0, 24, 8, d);
    chk(d, 32'h0);
    for (int i = 0; i < 65540; i++)
      arr(24'h0FFFF8 - 24'(i * 8), 64'h7, 1'b0);
    rd_valid <= 1'b0;
    @(posedge mclk);
    regs("saturate");
    for (int j = 0; j < 2; j++) begin
      arr(24'h000100, mk(3), 1'b0);
      rd_valid <= 1'b0;
      repeat (4) @(posedge mclk);
      reset_event <= (j == 0);
      deep_power_down <= (j == 1);
      repeat (3) @(posedge mclk);
      reset_event <= 1'b0;
      deep_power_down <= 1'b0;
      {ex_flag, ex_cnt, ex_trap} = '0;
      regs(j ? "power_down" : "reset_event");
    end
    pmask = mk(3);
    upd(24'h00ABC8, pmask, 1'b0);
    host.xfer(`EER_OP_UNIT_STATUS, 24'h00ABCD, 24, 8, d);
    chk(d, 32'h10);
    pmask = 64'h0;
    host.xfer(`EER_OP_UNIT_STATUS, 24'h000040, 24, 8, d);
    chk(d, 32'h0);
    @(posedge mclk);
    regs("probe");
    host.err_seen(seen);
    chk({31'h0, seen}, 32'h1);
    complete_run();
  end
endmodule // eer_top_tb
`default_nettype wire
